// File: include/dio_defines.svh
`ifndef DIO_DEFINES_SVH
`define DIO_DEFINES_SVH

// ***********************************************
// Clock and base tick
// ***********************************************
`define DIO_CLK_PERIOD_NS 10
`define DIO_TICK_US 100
`define DIO_TICK_CYCLES ((`DIO_TICK_US * 1000) / `DIO_CLK_PERIOD_NS)

// ***********************************************
// Input filter times, rounded up to whole ticks
// ***********************************************
`define DIO_FILT_0P1_US 100
`define DIO_FILT_1_US 1000
`define DIO_FILT_10_US 10000
`define DIO_FILT_20_US 20000
`define DIO_FILT_0P1_TICKS ((`DIO_FILT_0P1_US + `DIO_TICK_US - 1) / `DIO_TICK_US)
`define DIO_FILT_1_TICKS ((`DIO_FILT_1_US + `DIO_TICK_US - 1) / `DIO_TICK_US)
`define DIO_FILT_10_TICKS ((`DIO_FILT_10_US + `DIO_TICK_US - 1) / `DIO_TICK_US)
`define DIO_FILT_20_TICKS ((`DIO_FILT_20_US + `DIO_TICK_US - 1) / `DIO_TICK_US)

// ***********************************************
// Input extension times, rounded up to whole ticks
// ***********************************************
`define DIO_HOLD_1_US 1000
`define DIO_HOLD_15_US 15000
`define DIO_HOLD_100_US 100000
`define DIO_HOLD_200_US 200000
`define DIO_HOLD_1_TICKS ((`DIO_HOLD_1_US + `DIO_TICK_US - 1) / `DIO_TICK_US)
`define DIO_HOLD_15_TICKS ((`DIO_HOLD_15_US + `DIO_TICK_US - 1) / `DIO_TICK_US)
`define DIO_HOLD_100_TICKS ((`DIO_HOLD_100_US + `DIO_TICK_US - 1) / `DIO_TICK_US)
`define DIO_HOLD_200_TICKS ((`DIO_HOLD_200_US + `DIO_TICK_US - 1) / `DIO_TICK_US)

// ***********************************************
// Inrush masking window
// ***********************************************
`define DIO_INRUSH_MS 100
`define DIO_INRUSH_TICKS ((`DIO_INRUSH_MS * 1000) / `DIO_TICK_US)

// ***********************************************
// Parameter write indices and field positions
// ***********************************************
`define DIO_PAR_IN_UNIT 3'h0
`define DIO_PAR_IN_OPEN 3'h1
`define DIO_PAR_OUT_UNIT 3'h2
`define DIO_PAR_OUT_OPEN 3'h3
`define DIO_PAR_FAULT_MODE 3'h4
`define DIO_PAR_SYSTEM 3'h5
`define DIO_F_SUPPLY_EN 0
`define DIO_F_INRUSH_EN 1
`define DIO_F_FILT_LSB 2
`define DIO_F_HOLD_LSB 4
`define DIO_F_LOAD_EN 0
`define DIO_F_RECOVER 1
`define DIO_F_PRIO 0

// ***********************************************
// Reset values
// ***********************************************
`define DIO_RST_SUPPLY_EN 1'b0
`define DIO_RST_INRUSH_EN 1'b0
`define DIO_RST_FILT 2'h1
`define DIO_RST_HOLD 2'h1
`define DIO_RST_LOAD_EN 1'b0
`define DIO_RST_RECOVER 1'b0
`define DIO_RST_PRIO 1'b0

`endif

// File: include/dio_pkg.sv
package dio_pkg;
  typedef enum logic [1:0] {FILT_0P1, FILT_1, FILT_10, FILT_20} dio_filt_e;
  typedef enum logic [1:0] {HOLD_1, HOLD_15, HOLD_100, HOLD_200} dio_hold_e;
  typedef enum logic [1:0] {FAULT_CLEAR, FAULT_HOLD, FAULT_DRIVE_ON_FORCED} dio_fault_e;
  typedef enum logic {RECOVER_AUTO, RECOVER_MANUAL} dio_recover_e;
  typedef enum logic {PRIO_SWITCH, PRIO_HANDHELD} dio_prio_e;
endpackage : dio_pkg

// File: src/dio_in_cond.sv
`timescale 1ns/1ps

module dio_in_cond #(
  parameter int CNT_W = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic raw_i,
  input wire logic [CNT_W-1:0] filt_ticks_i,
  input wire logic [CNT_W-1:0] hold_ticks_i,
  output logic level_o
);

  logic accepted;
  logic stable_done;
  logic [CNT_W-1:0] stab_cnt;
  logic [CNT_W-1:0] hold_cnt;

  // ***********************************************
  // Debounce
  // ***********************************************
  assign stable_done = (stab_cnt >= filt_ticks_i);

  // Any return of the raw level, or an acceptance, restarts the stability count
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stab_cnt <= '0;
    end else if (raw_i == accepted || stable_done) begin
      stab_cnt <= '0;
    end else if (tick_i && !stable_done) begin
      stab_cnt <= stab_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      accepted <= 1'b0;
    end else if (raw_i != accepted && stable_done) begin
      accepted <= raw_i;
    end
  end

  // ***********************************************
  // Pulse extension
  // ***********************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_cnt <= '0;
    end else if (raw_i && !accepted && stable_done) begin
      hold_cnt <= hold_ticks_i;
    end else if (tick_i && hold_cnt != '0) begin
      hold_cnt <= hold_cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      level_o <= 1'b0;
    end else begin
      level_o <= accepted | (hold_cnt != '0);
    end
  end

  // ***********************************************
  // Checks
  // ***********************************************
  sequence seq_accept_rise;
    $rose(accepted) ##0 (hold_ticks_i != '0);
  endsequence

  chk_accept_stable: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(accepted) |-> $past(stable_done) && ($past(raw_i) == accepted) && (stab_cnt == '0))
    else $error("input level accepted before filter time");

  chk_hold_stretch: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_accept_rise |=> level_o [*2])
    else $error("accepted pulse not stretched");

  chk_level_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    (!accepted && hold_cnt == '0) |=> !level_o)
    else $error("input level high with no cause");

endmodule : dio_in_cond

// File: src/dio_channel_cond.sv
`timescale 1ns/1ps
`include "dio_defines.svh"

// Contract
// - A detected sensor supply short raises the unit error only while its enable is set.
// - Input device disconnection raises a channel error only on variants with detection.
// - Open signal lines are never reported; only the device connection flag counts.
// - With inrush filtering on, overcurrent is ignored for 100 ms after inrush.
// - Input filter time is 0.1, 1.0, 10 or 20 ms, default 1.0 ms.
// - Input hold time is 1.0, 15, 100 or 200 ms, default 15 ms.
// - A detected load short raises the output unit error only while its enable is set.
// - With automatic recovery the short error clears once the short is gone.
// - With manual recovery the short error stays latched until power-up reset; clearing the load short enable also drops it.
// - Output device disconnection raises a channel error only while enabled.
// - On communication fault each output clears, holds or drives on per its mode.
// - Per-channel fault modes apply only when the priority selects the handheld.
// - With the priority on switch, fault behaviour follows the unit hardware switch.
// - The latest write takes effect; in a same-cycle clash the handheld write wins over the controller.

module dio_channel_cond #(
  parameter int N_IN = 8,
  parameter int N_OUT = 8,
  parameter bit HAS_OC_DETECT = 1'b1,
  parameter int TICK_CYCLES = `DIO_TICK_CYCLES,
  parameter int INRUSH_TICKS = `DIO_INRUSH_TICKS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ctl_wr_i,
  input wire logic [2:0] ctl_addr_i,
  input wire logic [15:0] ctl_data_i,
  input wire logic ht_wr_i,
  input wire logic [2:0] ht_addr_i,
  input wire logic [15:0] ht_data_i,
  input wire logic [N_IN-1:0] raw_in_i,
  input wire logic [N_IN-1:0] input_device_open_i,
  input wire logic sensor_supply_short_i,
  input wire logic inrush_start_i,
  input wire logic [N_OUT-1:0] out_cmd_i,
  input wire logic [N_OUT-1:0] load_short_i,
  input wire logic [N_OUT-1:0] out_open_i,
  input wire logic comm_fault_i,
  input wire logic switch_hold_i,
  output logic [N_IN-1:0] in_level_o,
  output logic [N_IN-1:0] in_open_err_o,
  output logic supply_short_err_o,
  output logic inrush_mask_o,
  output logic [N_OUT-1:0] out_o,
  output logic [N_OUT-1:0] out_open_err_o,
  output logic load_short_err_o
);

  logic wr_en;
  logic [2:0] wr_addr;
  logic [15:0] wr_data;
  logic sensor_supply_short_detect_en;
  logic inrush_en;
  dio_pkg::dio_filt_e filt_sel;
  dio_pkg::dio_hold_e input_hold_time;
  logic [N_IN-1:0] open_circuit_detect_en;
  logic load_short_detect_en;
  dio_pkg::dio_recover_e short_recovery_select;
  logic [N_OUT-1:0] out_open_detect_en;
  logic [2*N_OUT-1:0] comm_fault_output_mode;
  dio_pkg::dio_prio_e prio_sel;
  logic [31:0] tick_cnt;
  logic tick;
  logic [11:0] filt_ticks;
  logic [11:0] hold_ticks;
  logic [11:0] inrush_cnt;
  logic any_short;

  // ***********************************************
  // Parameter writes
  // ***********************************************
  // Both sources share one write path; a same-cycle clash goes to the handheld
  always_comb begin
    wr_en = ctl_wr_i | ht_wr_i;
    wr_addr = ht_wr_i ? ht_addr_i : ctl_addr_i;
    wr_data = ht_wr_i ? ht_data_i : ctl_data_i;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sensor_supply_short_detect_en <= `DIO_RST_SUPPLY_EN;
      inrush_en <= `DIO_RST_INRUSH_EN;
      filt_sel <= dio_pkg::dio_filt_e'(`DIO_RST_FILT);
      input_hold_time <= dio_pkg::dio_hold_e'(`DIO_RST_HOLD);
    end else if (wr_en && wr_addr == `DIO_PAR_IN_UNIT) begin
      sensor_supply_short_detect_en <= wr_data[`DIO_F_SUPPLY_EN];
      inrush_en <= wr_data[`DIO_F_INRUSH_EN];
      filt_sel <= dio_pkg::dio_filt_e'(wr_data[`DIO_F_FILT_LSB +: 2]);
      input_hold_time <= dio_pkg::dio_hold_e'(wr_data[`DIO_F_HOLD_LSB +: 2]);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      open_circuit_detect_en <= '0;
    end else if (wr_en && wr_addr == `DIO_PAR_IN_OPEN) begin
      open_circuit_detect_en <= wr_data[N_IN-1:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      load_short_detect_en <= `DIO_RST_LOAD_EN;
      short_recovery_select <= dio_pkg::dio_recover_e'(`DIO_RST_RECOVER);
    end else if (wr_en && wr_addr == `DIO_PAR_OUT_UNIT) begin
      load_short_detect_en <= wr_data[`DIO_F_LOAD_EN];
      short_recovery_select <= dio_pkg::dio_recover_e'(wr_data[`DIO_F_RECOVER]);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_open_detect_en <= '0;
    end else if (wr_en && wr_addr == `DIO_PAR_OUT_OPEN) begin
      out_open_detect_en <= wr_data[N_OUT-1:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      comm_fault_output_mode <= '0;
    end else if (wr_en && wr_addr == `DIO_PAR_FAULT_MODE) begin
      comm_fault_output_mode <= wr_data[2*N_OUT-1:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prio_sel <= dio_pkg::dio_prio_e'(`DIO_RST_PRIO);
    end else if (wr_en && wr_addr == `DIO_PAR_SYSTEM) begin
      prio_sel <= dio_pkg::dio_prio_e'(wr_data[`DIO_F_PRIO]);
    end
  end

  // ***********************************************
  // Time base
  // ***********************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end

  assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

  always_comb begin
    case (filt_sel)
      dio_pkg::FILT_0P1: filt_ticks = 12'(`DIO_FILT_0P1_TICKS);
      dio_pkg::FILT_1: filt_ticks = 12'(`DIO_FILT_1_TICKS);
      dio_pkg::FILT_10: filt_ticks = 12'(`DIO_FILT_10_TICKS);
      dio_pkg::FILT_20: filt_ticks = 12'(`DIO_FILT_20_TICKS);
      default: filt_ticks = 12'(`DIO_FILT_1_TICKS);
    endcase
  end

  always_comb begin
    case (input_hold_time)
      dio_pkg::HOLD_1: hold_ticks = 12'(`DIO_HOLD_1_TICKS);
      dio_pkg::HOLD_15: hold_ticks = 12'(`DIO_HOLD_15_TICKS);
      dio_pkg::HOLD_100: hold_ticks = 12'(`DIO_HOLD_100_TICKS);
      dio_pkg::HOLD_200: hold_ticks = 12'(`DIO_HOLD_200_TICKS);
      default: hold_ticks = 12'(`DIO_HOLD_15_TICKS);
    endcase
  end

  // ***********************************************
  // Input channels
  // ***********************************************
  for (genvar i = 0; i < N_IN; i++) begin : g_in
    dio_in_cond #(
      .CNT_W(12)
    ) u_cond (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .raw_i(raw_in_i[i]),
      .filt_ticks_i(filt_ticks),
      .hold_ticks_i(hold_ticks),
      .level_o(in_level_o[i])
    );
  end

  // ***********************************************
  // Input unit faults
  // ***********************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      inrush_cnt <= '0;
    end else if (!inrush_en) begin
      inrush_cnt <= '0;
    end else if (inrush_start_i) begin
      inrush_cnt <= 12'(INRUSH_TICKS);
    end else if (tick && inrush_cnt != '0) begin
      inrush_cnt <= inrush_cnt - 12'h001;
    end
  end

  assign inrush_mask_o = (inrush_cnt != '0);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      supply_short_err_o <= 1'b0;
    end else begin
      // Overcurrent during the inrush window is not a short
      supply_short_err_o <= sensor_supply_short_detect_en & sensor_supply_short_i
                            & ~inrush_mask_o;
    end
  end

  // Only the device connection flag is watched, never the signal lines
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      in_open_err_o <= '0;
    end else if (HAS_OC_DETECT) begin
      in_open_err_o <= open_circuit_detect_en & input_device_open_i;
    end else begin
      in_open_err_o <= '0;
    end
  end

  // ***********************************************
  // Output unit faults
  // ***********************************************
  assign any_short = |load_short_i;

  // Manual recovery keeps the flag until reset; disabling detection drops it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      load_short_err_o <= 1'b0;
    end else begin
      load_short_err_o <= load_short_detect_en & (any_short
        | ((short_recovery_select == dio_pkg::RECOVER_MANUAL) & load_short_err_o));
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_open_err_o <= '0;
    end else begin
      out_open_err_o <= out_open_detect_en & out_open_i;
    end
  end

  // ***********************************************
  // Output channels
  // ***********************************************
  sequence seq_fault_handheld;
    comm_fault_i && prio_sel == dio_pkg::PRIO_HANDHELD;
  endsequence

  sequence seq_fault_switch;
    comm_fault_i && prio_sel == dio_pkg::PRIO_SWITCH;
  endsequence

  for (genvar i = 0; i < N_OUT; i++) begin : g_out
    dio_pkg::dio_fault_e mode;
    assign mode = dio_pkg::dio_fault_e'(comm_fault_output_mode[2*i +: 2]);

    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        out_o[i] <= 1'b0;
      end else if (!comm_fault_i) begin
        out_o[i] <= out_cmd_i[i];
      end else if (prio_sel == dio_pkg::PRIO_HANDHELD) begin
        case (mode)
          dio_pkg::FAULT_HOLD: out_o[i] <= out_o[i];
          dio_pkg::FAULT_DRIVE_ON_FORCED: out_o[i] <= 1'b1;
          default: out_o[i] <= 1'b0;
        endcase
      end else begin
        out_o[i] <= switch_hold_i ? out_o[i] : 1'b0;
      end
    end

    chk_fault_force_on: assert property (@(posedge clk_i) disable iff (rst_i)
      seq_fault_handheld ##0 (mode == dio_pkg::FAULT_DRIVE_ON_FORCED) |=> out_o[i])
      else $error("forced-on output not driven on");

    chk_fault_hold_out: assert property (@(posedge clk_i) disable iff (rst_i)
      seq_fault_handheld ##0 (mode == dio_pkg::FAULT_HOLD) |=> $stable(out_o[i]))
      else $error("held output changed during fault");

    chk_switch_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      seq_fault_switch ##0 !switch_hold_i |=> !out_o[i])
      else $error("switch clear did not drive output off");
  end

  // ***********************************************
  // Checks
  // ***********************************************
  sequence seq_ht_sys_write;
    ht_wr_i && ht_addr_i == `DIO_PAR_SYSTEM;
  endsequence

  chk_supply_short_err: assert property (@(posedge clk_i) disable iff (rst_i)
    supply_short_err_o |-> $past(sensor_supply_short_detect_en) && $past(sensor_supply_short_i)
      && !$past(inrush_mask_o))
    else $error("supply short error without enabled unmasked short");

  chk_inrush_window: assert property (@(posedge clk_i) disable iff (rst_i)
    (inrush_en && inrush_start_i) |=> (inrush_cnt == 12'(INRUSH_TICKS)) && inrush_mask_o)
    else $error("inrush window not opened");

  chk_in_open_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_open_err_o & ~($past(open_circuit_detect_en) & $past(input_device_open_i))) == '0)
    else $error("input open error without enabled disconnection");

  chk_auto_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (short_recovery_select == dio_pkg::RECOVER_AUTO && !any_short) |=> !load_short_err_o)
    else $error("auto recovery did not clear short error");

  chk_manual_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    (short_recovery_select == dio_pkg::RECOVER_MANUAL && load_short_detect_en
      && load_short_err_o) |=> load_short_err_o)
    else $error("manual short error released");

  chk_load_short_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (load_short_detect_en && any_short)
      |=> load_short_err_o)
    else $error("load short not reported");

  chk_load_short_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !load_short_detect_en |=> !load_short_err_o)
    else $error("load short error while detection disabled");

  chk_out_open_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    out_open_err_o == ($past(out_open_detect_en) & $past(out_open_i)))
    else $error("output open error mismatch");

  chk_param_latest: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_ht_sys_write |=> prio_sel == dio_pkg::dio_prio_e'($past(ht_data_i[`DIO_F_PRIO])))
    else $error("latest priority write not applied");

endmodule : dio_channel_cond

// File: verif/dio_field_model.sv
`timescale 1ns/1ps

// ****************************************
// Field sensors and loads
// ****************************************
module dio_field_model #(
  parameter int N_IN = 4,
  parameter int N_OUT = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [N_IN-1:0] sense_i,
  input wire logic chatter_i,
  input wire logic [N_OUT-1:0] drive_i,
  input wire logic lamp_i,
  input wire logic [N_OUT-1:0] short_i,
  input wire logic [N_OUT-1:0] unplug_i,
  output logic [N_IN-1:0] raw_o,
  output logic [N_OUT-1:0] load_short_o,
  output logic [N_OUT-1:0] out_open_o
);
  logic [N_OUT-1:0] drive_q;

  // Chatter flips the contact every cycle so it never settles
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      raw_o <= '0;
    end else if (chatter_i) begin
      raw_o <= ~raw_o;
    end else begin
      raw_o <= sense_i;
    end
  end

  // A cold lamp looks shorted for one cycle, the cycle after it is switched on
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      drive_q <= '0;
      load_short_o <= '0;
      out_open_o <= '0;
    end else begin
      drive_q <= drive_i;
      load_short_o <= short_i | ({N_OUT{lamp_i}} & drive_i & ~drive_q);
      out_open_o <= unplug_i;
    end
  end
endmodule : dio_field_model

// File: verif/digital_io_channel_conditioning_test.sv
`timescale 1ns/1ps
`include "dio_defines.svh"

// ****************************************
// Bench with reference model
// ****************************************
module digital_io_channel_conditioning_test;
  localparam int T = 10;
  localparam int ITK = 20;
  logic clk_i, rst_i, ctl_wr_i, ht_wr_i, sensor_supply_short_i, inrush_start_i;
  logic comm_fault_i, switch_hold_i, supply_short_err_o, inrush_mask_o, load_short_err_o;
  logic [2:0] ctl_addr_i, ht_addr_i;
  logic [15:0] ctl_data_i, ht_data_i;
  logic [3:0] raw_in_i, input_device_open_i, out_cmd_i, load_short_i, out_open_i;
  logic [3:0] in_level_o, in_open_err_o, out_o, out_open_err_o;
  logic [3:0] sense, sreq, unplug, nx, e_out, e_oopen, e_iopen;
  logic [1:0] m;
  logic chat, lamp, e_lerr, e_sup;
  logic [15:0] p [6];
  bit skip = 1'b0;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  int seed = 42;
  int ft [4] = '{`DIO_FILT_0P1_TICKS, `DIO_FILT_1_TICKS, `DIO_FILT_10_TICKS,
    `DIO_FILT_20_TICKS};
  int ht [4] = '{`DIO_HOLD_1_TICKS, `DIO_HOLD_15_TICKS, `DIO_HOLD_100_TICKS,
    `DIO_HOLD_200_TICKS};

  dio_channel_cond #(.N_IN(4), .N_OUT(4), .TICK_CYCLES(T), .INRUSH_TICKS(ITK)) u_dut (
    .clk_i, .rst_i, .ctl_wr_i, .ctl_addr_i, .ctl_data_i, .ht_wr_i, .ht_addr_i, .ht_data_i,
    .raw_in_i, .input_device_open_i, .sensor_supply_short_i, .inrush_start_i, .out_cmd_i,
    .load_short_i, .out_open_i, .comm_fault_i, .switch_hold_i, .in_level_o, .in_open_err_o,
    .supply_short_err_o, .inrush_mask_o, .out_o, .out_open_err_o, .load_short_err_o);

  dio_field_model #(.N_IN(4), .N_OUT(4)) u_field (.clk_i, .rst_i, .sense_i(sense),
    .chatter_i(chat), .drive_i(out_o), .lamp_i(lamp), .short_i(sreq), .unplug_i(unplug),
    .raw_o(raw_in_i), .load_short_o(load_short_i), .out_open_o(out_open_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Parameter store and expected fault-side outputs
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      p[0] <= 16'h0014;
      for (int i = 1; i < 6; i++) p[i] <= 16'h0000;
      {e_out, e_oopen, e_iopen, e_lerr, e_sup} <= '0;
    end else begin
      if (ht_wr_i) begin
        if (ht_addr_i < 3'h6) p[ht_addr_i] <= ht_data_i;
      end else if (ctl_wr_i && ctl_addr_i < 3'h6) begin
        p[ctl_addr_i] <= ctl_data_i;
      end
      for (int i = 0; i < 4; i++) begin
        m = p[4][2*i+:2];
        nx[i] = (m == 2'h2) | ((m == 2'h1) & e_out[i]);
        if (!p[5][0]) nx[i] = switch_hold_i & e_out[i];
        if (!comm_fault_i) nx[i] = out_cmd_i[i];
      end
      e_out <= nx;
      e_lerr <= p[2][0] & ((|load_short_i) | (p[2][1] & e_lerr));
      e_oopen <= p[3][3:0] & out_open_i;
      e_iopen <= p[1][3:0] & input_device_open_i;
      e_sup <= p[0][0] & sensor_supply_short_i;
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  always @(negedge clk_i) begin
    if (!rst_i) begin
      check("out", out_o, e_out);
      check("load_short_err", load_short_err_o, e_lerr);
      check("out_open_err", out_open_err_o, e_oopen);
      check("in_open_err", in_open_err_o, e_iopen);
      if (!skip) check("supply_err", supply_short_err_o, e_sup);
    end
  end

  task automatic tally_and_finish;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic wr(input logic hh, input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_i);
    ctl_wr_i <= !hh;
    ht_wr_i <= hh;
    {ctl_addr_i, ht_addr_i, ctl_data_i, ht_data_i} <= {a, a, d, d};
    @(posedge clk_i);
    ctl_wr_i <= 1'b0;
    ht_wr_i <= 1'b0;
  endtask : wr

  // Raise all inputs, time the rise, drop them, time the stretched high
  task automatic pulse(input int f, input int h);
    int n;
    n = 0;
    @(posedge clk_i);
    sense <= 4'hF;
    while (in_level_o !== 4'hF && n < 30000) begin
      @(negedge clk_i);
      n++;
    end
    check("filter", n >= (f - 1) * T && n <= f * T + 4, 1'b1);
    @(posedge clk_i);
    sense <= 4'h0;
    n = 0;
    while (in_level_o !== 4'h0 && n < 30000) begin
      @(negedge clk_i);
      n++;
    end
    check("hold", n + 3 >= (h - 1) * T && n <= ((h > f ? h : f + 1) + 2) * T, 1'b1);
  endtask : pulse

  task automatic rnd(input int k);
    logic [31:0] r, q;
    repeat (k) begin
      @(posedge clk_i);
      r = $random(seed);
      q = $random(seed);
      out_cmd_i <= r[3:0];
      comm_fault_i <= r[4] | r[5];
      switch_hold_i <= r[6];
      sreq <= (r[9:7] == 3'h0) ? r[13:10] : 4'h0;
      unplug <= r[17:14];
      input_device_open_i <= r[21:18];
      sensor_supply_short_i <= r[22];
      lamp <= r[23];
      ctl_wr_i <= r[24] & r[25];
      ht_wr_i <= r[26] & r[27];
      ctl_addr_i <= 3'h1 + 3'(q[2:0] % 3'h7);
      ht_addr_i <= 3'h1 + 3'(q[5:3] % 3'h7);
      ctl_data_i <= q[21:6];
      ht_data_i <= {q[31:22], q[5:0]};
    end
    @(posedge clk_i);
    ctl_wr_i <= 1'b0;
    ht_wr_i <= 1'b0;
  endtask : rnd

  initial begin
    rst_i = 1'b1;
    {ctl_wr_i, ht_wr_i, sensor_supply_short_i, inrush_start_i, comm_fault_i} = '0;
    {switch_hold_i, ctl_addr_i, ht_addr_i, ctl_data_i, ht_data_i} = '0;
    {input_device_open_i, out_cmd_i, sense, sreq, unplug, chat, lamp} = '0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    pulse(ft[1], ht[1]);
    for (int i = 0; i < 4; i++) begin
      wr(1'b0, 3'h0, 16'(i << 2));
      pulse(ft[i], ht[0]);
      wr(1'b1, 3'h0, 16'(i << 4));
      pulse(ft[0], ht[i]);
    end
    wr(1'b0, 3'h0, 16'h0004);
    @(posedge clk_i);
    chat <= 1'b1;
    repeat (300) @(negedge clk_i) check("chatter", in_level_o, 4'h0);
    @(posedge clk_i);
    chat <= 1'b0;
    skip = 1'b1;
    wr(1'b0, 3'h0, 16'h0003);
    @(posedge clk_i);
    inrush_start_i <= 1'b1;
    @(posedge clk_i);
    inrush_start_i <= 1'b0;
    sensor_supply_short_i <= 1'b1;
    repeat (3) @(negedge clk_i);
    check("inrush_on", {inrush_mask_o, supply_short_err_o}, 2'b10);
    repeat ((ITK + 2) * T) @(negedge clk_i);
    check("inrush_end", {inrush_mask_o, supply_short_err_o}, 2'b01);
    wr(1'b0, 3'h0, 16'h0001);
    @(posedge clk_i);
    inrush_start_i <= 1'b1;
    @(posedge clk_i);
    inrush_start_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    check("inrush_off", {inrush_mask_o, supply_short_err_o}, 2'b01);
    skip = 1'b0;
    rnd(800);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rnd(400);
    tally_and_finish();
  end
endmodule : digital_io_channel_conditioning_test
